/* File: verilog/two_wire_pkg.sv */
// constants, states and carriers for the two-wire serial master
package two_wire_pkg;
	// register byte offsets
	localparam logic [3:0] DATA_OFFSET = 4'h0;
	localparam logic [3:0] CTRL_OFFSET = 4'h4;
	localparam logic [3:0] STAT_OFFSET = 4'h8;
	localparam logic [3:0] DIV_OFFSET = 4'hC;
	// control field positions
	localparam int ENABLE_BIT = 0;
	localparam int RESP_SEL_BIT = 1;
	localparam int END_REQ_BIT = 2;
	localparam int BEGIN_REQ_BIT = 3;
	// reset values
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	// serial bit slot: sixteen ticks, low half then high half
	localparam logic [3:0] LAST_PHASE = 4'hF;
	localparam logic [3:0] CHANGE_PHASE = 4'h4;
	localparam logic [3:0] HIGH_PHASE = 4'h8;
	localparam logic [3:0] EDGE_PHASE = 4'hC;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_HOLD = 3'b010,
		ST_BYTE = 3'b011,
		ST_STOP = 3'b100
	} state_e;

	typedef struct packed
	{
		logic resp_sel;
		logic enable;
	} ctrl_s;

	typedef struct packed
	{
		logic [2:0] zero;
		logic cmd_pending;
		logic busy;
		logic done;
		logic data_valid;
		logic ack_level;
	} status_s;
endpackage

/* File: verilog/two_wire_serial_master.sv */
// two-wire serial bus master with a register slave on the system bus
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module two_wire_serial_master
	import two_wire_pkg::*;
#(
	parameter int DIV_WIDTH = 16
)
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out
);
	if (DIV_WIDTH < 1 || DIV_WIDTH > 16)
	begin : g_bad_width
		$error("divider width must be 1 to 16");
	end

	state_e state_reg;
	ctrl_s ctrl_reg;
	logic [15:0] div_reg;
	logic [DIV_WIDTH-1:0] presc_reg;
	logic [3:0] phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] data_reg;
	logic [7:0] shift_reg;
	logic data_valid_reg, ack_level_reg, begin_pend_reg, end_pend_reg;
	logic from_idle_reg, first_byte_reg, rx_mode_reg, nack_sent_reg, addr_read_reg;
	logic drive_low_reg, sample_reg, busy_reg, scl_prev_reg, sda_prev_reg;
	logic tick, stretched, advance, slot_end, wr_fire, rd_fire;
	logic scl_low_next, sda_low_next, start_seen, stop_seen, done_flag;
	logic begin_take, end_take, load_tx, load_rx, data_read;
	status_s status;

	function automatic logic hit(input logic [31:0] addr, input logic [3:0] offset);
		hit = (addr[3:0] == offset) && (addr[31:4] == 28'h0000000);
	endfunction

	// system bus slave: one write, one read at a time
	assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out;
	assign s_axi_awready_out = wr_fire;
	assign s_axi_wready_out = wr_fire;
	assign rd_fire = s_axi_arvalid_in && !s_axi_rvalid_out;
	assign s_axi_arready_out = rd_fire;
	assign data_read = rd_fire && hit(s_axi_araddr_in, DATA_OFFSET);

	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= (s_axi_awaddr_in[31:4] == 28'h0000000 && s_axi_awaddr_in[1:0] == 2'b00)
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready_in)
			s_axi_bvalid_out <= 1'b0;
	end

	assign done_flag = (state_reg != ST_BYTE);
	always_comb
	begin
		status = '0;
		status.cmd_pending = begin_pend_reg || end_pend_reg;
		status.busy = busy_reg;
		status.done = done_flag;
		status.data_valid = data_valid_reg;
		status.ack_level = ack_level_reg;
	end

	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= RESP_OKAY;
			if (hit(s_axi_araddr_in, DATA_OFFSET))
				s_axi_rdata_out <= {24'h000000, data_reg};
			else if (hit(s_axi_araddr_in, CTRL_OFFSET))
				s_axi_rdata_out <= {30'h00000000, ctrl_reg};
			else if (hit(s_axi_araddr_in, STAT_OFFSET))
				s_axi_rdata_out <= {24'h000000, status};
			else if (hit(s_axi_araddr_in, DIV_OFFSET))
				s_axi_rdata_out <= {16'h0000, div_reg};
			else
			begin
				s_axi_rdata_out <= 32'h00000000;
				s_axi_rresp_out <= RESP_SLVERR;
			end
		end
		else if (s_axi_rready_in)
			s_axi_rvalid_out <= 1'b0;
	end

	// control and divider registers; request bits only ever set by software
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ctrl_reg <= '0;
			div_reg <= DIV_RESET;
		end
		else if (wr_fire && hit(s_axi_awaddr_in, CTRL_OFFSET) && s_axi_wstrb_in[0])
		begin
			ctrl_reg.enable <= s_axi_wdata_in[ENABLE_BIT];
			ctrl_reg.resp_sel <= s_axi_wdata_in[RESP_SEL_BIT];
		end
		else if (wr_fire && hit(s_axi_awaddr_in, DIV_OFFSET))
		begin
			if (s_axi_wstrb_in[0])
				div_reg[7:0] <= s_axi_wdata_in[7:0];
			if (s_axi_wstrb_in[1])
				div_reg[15:8] <= s_axi_wdata_in[15:8];
		end
	end

	// queued conditions; a software set wins over the engine's clear
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			begin_pend_reg <= 1'b0;
			end_pend_reg <= 1'b0;
		end
		else
		begin
			if (begin_take)
				begin_pend_reg <= 1'b0;
			if (end_take)
				end_pend_reg <= 1'b0;
			if (wr_fire && hit(s_axi_awaddr_in, CTRL_OFFSET) && s_axi_wstrb_in[0])
			begin
				if (s_axi_wdata_in[BEGIN_REQ_BIT])
					begin_pend_reg <= 1'b1;
				if (s_axi_wdata_in[END_REQ_BIT])
					end_pend_reg <= 1'b1;
			end
		end
	end

	// prescaler: one tick per divider+1 clocks, sixteen ticks per bit slot
	assign tick = (presc_reg == '0);
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
			presc_reg <= '0;
		else if (tick)
			presc_reg <= div_reg[DIV_WIDTH-1:0];
		else
			presc_reg <= presc_reg - 1'b1;
	end

	// a slave holding the clock low freezes the high half
	assign stretched = (phase_reg == HIGH_PHASE) && !scl_low_next && !scl_in;
	assign advance = tick && !stretched && state_reg != ST_IDLE && state_reg != ST_HOLD;
	assign slot_end = advance && phase_reg == LAST_PHASE;
	assign begin_take = ctrl_reg.enable && begin_pend_reg && (state_reg == ST_IDLE || state_reg == ST_HOLD);
	assign end_take = end_pend_reg && !begin_take && (state_reg == ST_IDLE || state_reg == ST_HOLD);
	// reads keep going until a nack has gone out or a condition is queued
	assign load_tx = state_reg == ST_HOLD && !begin_pend_reg && !end_pend_reg && !rx_mode_reg
		&& data_valid_reg;
	assign load_rx = state_reg == ST_HOLD && !begin_pend_reg && !end_pend_reg && rx_mode_reg
		&& !data_valid_reg && !nack_sent_reg;

	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
			phase_reg <= 4'h0;
		else if (state_reg == ST_IDLE || state_reg == ST_HOLD)
			phase_reg <= 4'h0;
		else if (advance)
			phase_reg <= phase_reg + 4'h1;
	end

	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
			state_reg <= ST_IDLE;
		else if (!ctrl_reg.enable)
			state_reg <= ST_IDLE;
		else
			case (state_reg)
				ST_IDLE:
				begin
					if (begin_take)
						state_reg <= ST_START;
				end
				ST_HOLD:
				begin
					if (begin_take)
						state_reg <= ST_START;
					else if (end_take)
						state_reg <= ST_STOP;
					else if (load_tx || load_rx)
						state_reg <= ST_BYTE;
				end
				ST_START:
				begin
					if (slot_end)
						state_reg <= ST_HOLD;
				end
				ST_BYTE:
				begin
					if (slot_end && bit_cnt_reg == ACK_SLOT)
						state_reg <= ST_HOLD;
				end
				ST_STOP:
				begin
					if (slot_end)
						state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
	end

	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			from_idle_reg <= 1'b0;
			first_byte_reg <= 1'b0;
			rx_mode_reg <= 1'b0;
			nack_sent_reg <= 1'b0;
			addr_read_reg <= 1'b0;
		end
		else if (begin_take)
		begin
			from_idle_reg <= (state_reg == ST_IDLE);
			first_byte_reg <= 1'b1;
			rx_mode_reg <= 1'b0;
			nack_sent_reg <= 1'b0;
		end
		else if (load_tx)
			addr_read_reg <= first_byte_reg && data_reg[0];
		else if (slot_end && state_reg == ST_BYTE && bit_cnt_reg == ACK_SLOT)
		begin
			first_byte_reg <= 1'b0;
			// direction turns only when the slave acknowledged a read address
			if (addr_read_reg && !sample_reg)
				rx_mode_reg <= 1'b1;
			addr_read_reg <= 1'b0;
			if (rx_mode_reg && ctrl_reg.resp_sel)
				nack_sent_reg <= 1'b1;
		end
	end

	// shift register: transmit from bit 7, sampled bit enters at bit 0
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			shift_reg <= 8'hFF;
			bit_cnt_reg <= 4'h0;
			sample_reg <= 1'b1;
		end
		else if (load_tx)
		begin
			shift_reg <= data_reg;
			bit_cnt_reg <= 4'h0;
		end
		else if (load_rx)
		begin
			shift_reg <= 8'hFF;
			bit_cnt_reg <= 4'h0;
		end
		else if (advance && state_reg == ST_BYTE)
		begin
			if (phase_reg == EDGE_PHASE)
				sample_reg <= sda_in;
			if (phase_reg == LAST_PHASE && bit_cnt_reg != ACK_SLOT)
			begin
				shift_reg <= {shift_reg[6:0], sample_reg};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// data register: software write or a received byte marks it valid
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			data_reg <= DATA_RESET;
			data_valid_reg <= 1'b0;
			ack_level_reg <= 1'b0;
		end
		else
		begin
			if (load_tx || (data_read && rx_mode_reg))
				data_valid_reg <= 1'b0;
			if (wr_fire && hit(s_axi_awaddr_in, DATA_OFFSET) && s_axi_wstrb_in[0])
			begin
				data_reg <= s_axi_wdata_in[7:0];
				data_valid_reg <= 1'b1;
			end
			if (slot_end && state_reg == ST_BYTE && bit_cnt_reg == ACK_SLOT)
			begin
				if (rx_mode_reg)
				begin
					data_reg <= shift_reg;
					data_valid_reg <= 1'b1;
				end
				else
					ack_level_reg <= sample_reg;
			end
		end
	end

	// sda level for the byte slot, changed in mid low half only
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
			drive_low_reg <= 1'b0;
		else if (state_reg == ST_START || state_reg == ST_STOP)
			drive_low_reg <= 1'b1;
		else if (advance && state_reg == ST_BYTE && phase_reg == CHANGE_PHASE)
		begin
			if (bit_cnt_reg != ACK_SLOT)
				drive_low_reg <= !shift_reg[7];
			else if (rx_mode_reg)
				drive_low_reg <= !ctrl_reg.resp_sel;
			else
				drive_low_reg <= 1'b0;
		end
	end

	always_comb
	begin
		scl_low_next = 1'b0;
		sda_low_next = 1'b0;
		case (state_reg)
			ST_START:
			begin
				scl_low_next = !from_idle_reg && phase_reg < HIGH_PHASE;
				sda_low_next = phase_reg >= EDGE_PHASE;
			end
			ST_HOLD:
			begin
				scl_low_next = 1'b1;
				sda_low_next = drive_low_reg;
			end
			ST_BYTE:
			begin
				scl_low_next = phase_reg < HIGH_PHASE;
				sda_low_next = drive_low_reg;
			end
			ST_STOP:
			begin
				scl_low_next = phase_reg < HIGH_PHASE;
				sda_low_next = phase_reg < EDGE_PHASE;
			end
			default:
			begin
				scl_low_next = 1'b0;
				sda_low_next = 1'b0;
			end
		endcase
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end
		else
		begin
			scl_oe_out <= scl_low_next;
			sda_oe_out <= sda_low_next;
		end
	end

	// bus watcher sees our own conditions as well as anyone else's
	assign start_seen = scl_prev_reg && scl_in && sda_prev_reg && !sda_in;
	assign stop_seen = scl_prev_reg && scl_in && !sda_prev_reg && sda_in;
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			busy_reg <= 1'b0;
		end
		else
		begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
			if (start_seen)
				busy_reg <= 1'b1;
			else if (stop_seen)
				busy_reg <= 1'b0;
		end
	end

	a_start_clock_high: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_START && $rose(sda_oe_out) |-> !scl_oe_out)
		else $error("start edge with clock low");
	a_stop_clock_high: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_STOP && $fell(sda_oe_out) |-> !scl_oe_out)
		else $error("stop edge with clock low");
	a_data_stable_high: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_BYTE && !scl_oe_out && $past(!scl_oe_out) |-> $stable(sda_oe_out))
		else $error("data moved while clock high");
	a_byte_starts_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_BYTE && $past(state_reg) != ST_BYTE |-> bit_cnt_reg == 4'h0)
		else $error("byte did not start at bit zero");
	a_tx_ack_release: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_BYTE && bit_cnt_reg == ACK_SLOT && !rx_mode_reg && phase_reg >= 4'h6 |-> !sda_oe_out)
		else $error("transmitter held data during acknowledge");
	a_rx_ack_level: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_BYTE && bit_cnt_reg == ACK_SLOT && rx_mode_reg && $rose(phase_reg == 4'h5)
		|-> drive_low_reg == !$past(ctrl_reg.resp_sel))
		else $error("sent acknowledge level wrong");
	a_divider_reload: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		tick |=> presc_reg == $past(div_reg[DIV_WIDTH-1:0]))
		else $error("prescaler did not reload");
	a_busy_on_start: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		start_seen |=> busy_reg)
		else $error("busy not set after start");
	a_byte_done_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		state_reg == ST_BYTE && slot_end && bit_cnt_reg == ACK_SLOT && ctrl_reg.enable
		|=> state_reg == ST_HOLD && done_flag)
		else $error("done flag not raised after acknowledge");
	a_stretch_wait: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		stretched && state_reg == ST_BYTE && ctrl_reg.enable |=> phase_reg == HIGH_PHASE)
		else $error("clock advanced during stretch");
endmodule

/* File: bench/two_wire_slave_model.sv */
// behavioural two-wire slave: acks its address and general call, returns a fixed byte
`timescale 1ns/10ps
module two_wire_slave_model
#(
	parameter logic [6:0] OWN_ADDR = 7'h2A,
	parameter logic [7:0] READ_BYTE = 8'h3C,
	parameter int STRETCH = 40
)
(
	input wire logic clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic stretch_in,
	output logic scl_oe_out,
	output logic sda_oe_out,
	output logic [7:0] rx_byte_out,
	output logic ack_seen_out
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic first = 1'b0;
	logic sel = 1'b0;
	logic rd = 1'b0;
	logic hit;
	logic [7:0] sr = 8'h00;
	int cnt = 0;
	int hold = 0;
	assign hit = sr[7:1] == OWN_ADDR || sr == 8'h00;
	initial
	begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
		rx_byte_out = 8'h00;
		ack_seen_out = 1'b0;
	end
	// lines are sampled on the system clock, like a real oversampling slave
	always @(posedge clk_in)
	begin
		scl_q <= scl_in;
		sda_q <= sda_in;
		if (hold > 0)
			hold <= hold - 1;
		else
			scl_oe_out <= 1'b0;
		if (scl_q && scl_in && sda_q && !sda_in)
		begin
			cnt <= 0;
			first <= 1'b1;
			sel <= 1'b0;
			rd <= 1'b0;
		end
		else if (scl_q && scl_in && !sda_q && sda_in)
			sel <= 1'b0;
		else if (!scl_q && scl_in)
		begin
			if (cnt < 8)
				sr <= {sr[6:0], sda_in};
			else if (rd && sel && !sda_oe_out)
			begin
				ack_seen_out <= sda_in;
				sel <= !sda_in;
			end
			cnt <= (cnt == 8) ? 0 : cnt + 1;
		end
		else if (scl_q && !scl_in)
		begin
			if (stretch_in)
			begin
				scl_oe_out <= 1'b1;
				hold <= STRETCH;
			end
			// data only moves just after the clock falls
			if (cnt == 8 && first)
			begin
				first <= 1'b0;
				sel <= hit;
				rd <= sr[0] && sr[7:1] == OWN_ADDR;
				sda_oe_out <= hit;
			end
			else if (cnt == 8 && sel && !rd)
			begin
				rx_byte_out <= sr;
				sda_oe_out <= 1'b1;
			end
			else
				sda_oe_out <= sel && rd && cnt < 8 && !READ_BYTE[7 - cnt];
		end
	end
endmodule

/* File: bench/tb.sv */
// self-checking bench: register access over the system bus, transfers to a model slave
`timescale 1ns/10ps
module tb
	import two_wire_pkg::*;
;
	localparam logic [6:0] SLAVE = 7'h2A;
	localparam int DIV = 1;
	localparam logic [31:0] DATA_A = 32'(DATA_OFFSET);
	localparam logic [31:0] CTRL_A = 32'(CTRL_OFFSET);
	localparam logic [31:0] STAT_A = 32'(STAT_OFFSET);
	localparam logic [31:0] DIV_A = 32'(DIV_OFFSET);
	localparam logic [31:0] EN = 32'h1 << ENABLE_BIT;
	localparam logic [31:0] NACK = 32'h1 << RESP_SEL_BIT;
	localparam logic [31:0] STOP = 32'h1 << END_REQ_BIT;
	localparam logic [31:0] GO = 32'h1 << BEGIN_REQ_BIT;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_val;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, stretch = 0;
	logic awready, wready, bvalid, arready, rvalid, ack_seen;
	logic [1:0] bresp, rresp, resp;
	logic scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe, scl_q, sda_q;
	logic [7:0] rx_byte;
	int err_count = 0, comparisons = 0, cyc = 0, last_rise = 0, per = 0, rises = 0, starts = 0, stops = 0, r0;
	// open-drain lines with pull-ups
	wire scl = (scl_oe ? scl_o : 1'b1) & !s_scl_oe;
	wire sda = (sda_oe ? sda_o : 1'b1) & !s_sda_oe;
	always #5 clk = ~clk;
	two_wire_serial_master #(.DIV_WIDTH(16)) u_two_wire_serial_master (.sys_clk_in(clk), .reset_in(rst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe));
	two_wire_slave_model #(.OWN_ADDR(SLAVE)) u_two_wire_slave_model (.clk_in(clk), .scl_in(scl), .sda_in(sda),
		.stretch_in(stretch), .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe), .rx_byte_out(rx_byte),
		.ack_seen_out(ack_seen));
	// wire monitor: clock period, pulse count, start and stop conditions
	always @(posedge clk)
	begin
		cyc++;
		if (scl && !scl_q)
		begin
			per = cyc - last_rise;
			last_rise = cyc;
			rises++;
		end
		if (scl && scl_q && sda_q && !sda)
			starts++;
		if (scl && scl_q && !sda_q && sda)
			stops++;
		scl_q = scl;
		sda_q = sda;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// bus handshakes end only when the answer comes, a hang is left to the watchdog; status polls give up after 400 retries
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		@(posedge clk);
		while (awready !== 1'b1 || wready !== 1'b1)
			@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		@(posedge clk);
		while (bvalid !== 1'b1)
			@(posedge clk);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge clk);
		while (arready !== 1'b1)
			@(posedge clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		@(posedge clk);
		while (rvalid !== 1'b1)
			@(posedge clk);
		rd_val = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_status(input logic [7:0] mask, input logic [7:0] val);
		int n;
		rd(STAT_A);
		for (n = 0; n < 400 && (rd_val[7:0] & mask) !== val; n++)
			rd(STAT_A);
		check("status wait", 32'(rd_val[7:0] & mask), 32'(val));
	endtask
	task automatic send(input logic [7:0] b, input logic [31:0] ctl, input logic ack);
		// condition first: in hold a valid byte would go out at once, before a restart
		if (ctl != 0)
			wr(CTRL_A, ctl);
		wr(DATA_A, {24'h000000, b});
		wait_status(8'h16, 8'h04);
		check("ack level", 32'(rd_val[0]), 32'(ack));
	endtask
	task automatic stop_bus;
		wr(CTRL_A, EN | STOP);
		wait_status(8'h18, 8'h00);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(STAT_A);
		check("status reset", rd_val, 32'h4);
		rd(DIV_A);
		check("divider reset", rd_val, 32'(DIV_RESET));
		check("read resp", 32'(resp), 32'(RESP_OKAY));
		// small test value: the prescaler runs one full count of it before the next divider takes hold
		wr(DIV_A, 32'h0102);
		rd(DIV_A);
		check("divider rw", rd_val, 32'h0102);
		rd(32'h10);
		check("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
		check("unmapped data", rd_val, 32'h0);
		wr(32'h100, 32'h0);
		check("out of range write resp", 32'(resp), 32'(RESP_SLVERR));
		wr(STAT_A, 32'hFF);
		check("status write resp", 32'(resp), 32'(RESP_OKAY));
		rd(STAT_A);
		check("status read only", rd_val, 32'h4);
		wr(DIV_A, DIV);
		wr(CTRL_A, EN);
		send({SLAVE, 1'b0}, EN | GO, 1'b0);
		check("bit period", per, 16 * (DIV + 1));
		rd(STAT_A);
		check("busy", 32'(rd_val[3]), 32'h1);
		r0 = rises;
		stretch <= 1'b1;
		send(8'hA5, 0, 1'b0);
		stretch <= 1'b0;
		check("pulses per byte", rises - r0, 9);
		check("slave byte", 32'(rx_byte), 32'hA5);
		stop_bus();
		send({7'h33, 1'b0}, EN | GO, 1'b1);
		stop_bus();
		send(8'h01, EN | GO, 1'b1);
		send({SLAVE, 1'b0}, EN | GO, 1'b0);
		stop_bus();
		send(8'h00, EN | GO, 1'b0);
		send(8'h5A, 0, 1'b0);
		check("general call byte", 32'(rx_byte), 32'h5A);
		stop_bus();
		// one slot is sixteen divided ticks; allow start, address and one byte
		wr(DATA_A, {24'h000000, SLAVE, 1'b1});
		wr(CTRL_A, EN | NACK | GO);
		repeat (24 * 16 * (DIV + 1)) @(posedge clk);
		wait_status(8'h16, 8'h06);
		r0 = rises;
		repeat (300) @(posedge clk);
		check("no byte after nack", rises - r0, 0);
		check("master nack", 32'(ack_seen), 32'h1);
		rd(DATA_A);
		check("read byte", rd_val, 32'h3C);
		rd(STAT_A);
		check("read consumed", 32'(rd_val[1]), 32'h0);
		wr(CTRL_A, EN | NACK | STOP);
		wait_status(8'h18, 8'h00);
		wr(CTRL_A, 32'h0);
		check("starts", starts, 6);
		check("stops", stops, 5);
		report_and_stop();
	end
endmodule
